// ---- eipu_pkg.sv ----
// Constants and types shared by the external pin interrupt unit
package eipu_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  EIPU_IDX_PC_MASK    = 8'h10;
   localparam logic [7:0]  EIPU_IDX_PC_FLAG    = 8'h11;
   localparam logic [7:0]  EIPU_IDX_PC_CTRL    = 8'h12;
   localparam logic [7:0]  EIPU_IDX_EXT_MASK   = 8'h13;
   localparam logic [7:0]  EIPU_IDX_EXT_FLAG   = 8'h14;
   localparam logic [7:0]  EIPU_IDX_EXT_SENSE  = 8'h15;
   localparam logic [7:0]  EIPU_IDX_IRQ_STATUS = 8'h16;
   localparam logic [7:0]  EIPU_IDX_IRQ_MASK   = 8'h17;
   localparam logic [7:0]  EIPU_IDX_NONE       = 8'hff;

   // Field positions
   localparam int          EIPU_FLAG_BIT       = 0;
   localparam int          EIPU_ENABLE_BIT     = 0;
   localparam int          EIPU_SENSE_LSB      = 0;
   localparam int          EIPU_SENSE_MSB      = 1;
   localparam int          EIPU_STAT_EXT_BIT   = 0;
   localparam int          EIPU_STAT_PC_BIT    = 1;
   localparam int          EIPU_PC_PINS        = 4;
   localparam int          EIPU_STAT_W         = 2;

   // Reset values
   localparam logic [3:0]  EIPU_PC_MASK_RST    = 4'h0;
   localparam logic [1:0]  EIPU_SENSE_RST      = 2'h0;
   localparam logic [1:0]  EIPU_STAT_RST       = 2'h0;
   localparam logic        EIPU_BIT_RST        = 1'b0;
   localparam logic        EIPU_PIN_IDLE       = 1'b1;

   // Dispatch vectors
   localparam logic [15:0] EIPU_VEC_EXT        = 16'h0001;
   localparam logic [15:0] EIPU_VEC_PINCHG     = 16'h0002;
   localparam logic [15:0] EIPU_VEC_NONE       = 16'h0000;

   // Synchroniser depth
   localparam int          EIPU_SYNC_STAGES    = 2;

   typedef enum logic [1:0] {
      EIPU_SENSE_LOW  = 2'b00,
      EIPU_SENSE_ANY  = 2'b01,
      EIPU_SENSE_FALL = 2'b10,
      EIPU_SENSE_RISE = 2'b11
   } eipu_sense_t;

endpackage : eipu_pkg

// ---- eipu_sync_edge.sv ----
// Two-stage pin synchroniser with edge detection on the sampled value
`timescale 1ns/10ps
module eipu_sync_edge
   import eipu_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rstn_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o,
   output logic      [WIDTH-1:0] change_o
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;

   // Only the second stage reads the first one
   // Reset to the pulled-up idle level, so release shows no false edge or low level
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         meta    <= {WIDTH{EIPU_PIN_IDLE}};
         level_o <= {WIDTH{EIPU_PIN_IDLE}};
         prev    <= {WIDTH{EIPU_PIN_IDLE}};
      end else begin
         meta    <= pin_i;
         level_o <= meta;
         prev    <= level_o;
      end
   end

   // Edges are taken from the synchronised value and its previous sample
   assign rise_o   = level_o & ~prev;
   assign fall_o   = ~level_o & prev;
   assign change_o = level_o ^ prev;

endmodule : eipu_sync_edge

// ---- eipu_top.sv ----
// External pin interrupt unit with AHB-Lite register access
`timescale 1ns/10ps
// Functional notes
// [R01] Pin interrupt request only while global and external enable are both set.
// [R02] Sense field bits 1:0: low level, any change, falling, rising edge.
// [R03] Pin is sampled into the clock domain before edges are detected.
// [R04] Pulses longer than one clock period are recognised in edge modes.
// [R05] Outside party holds pin low until current instruction completes.
// [R06] Reserved register bits read zero; writes to them do nothing.
// [R07] Pin activity raises requests even when pin is an output.
// [R08] Edge or change trigger sets the external flag, bit 0.
// [R09] Flags clear on dispatch or by writing one to them.
// [R10] In low-level mode flag stays zero; request follows pin level.
// [R11] Pin-change request only while its enable and global enable set.
// [R12] Change on any masked pin sets the pin-change flag, bit 0.
// [R13] Each mask bit enables change detection on its own pin.
// [R14] Each request dispatches to its own vector.
// [R15] External vector 0x0001, pin-change vector 0x0002.
// [R16] Pin-change detection needs no I/O clock history of its own; code compares clocked current and previous samples.
// [R17] Low-level detection is level based; edges need the running clock.
// [R18] Two-stage synchroniser per pin, current versus previous sample.
module eipu_top
   import eipu_pkg::*;
#(
   parameter int PC_PINS = EIPU_PC_PINS
) (
   input  wire logic               sys_clk_i,
   input  wire logic               rstn_i,
   input  wire logic               hsel_i,
   input  wire logic [31:0]        haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [31:0]        hwdata_i,
   input  wire logic               hready_i,
   output logic      [31:0]        hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   input  wire logic               ext_irq_pin_i,
   input  wire logic [PC_PINS-1:0] pinchg_pin_i,
   input  wire logic               global_irq_en_i,
   input  wire logic               ext_ack_i,
   input  wire logic               pinchg_ack_i,
   output logic                    ext_req_o,
   output logic                    pinchg_request_o,
   output logic      [15:0]        vector_o,
   output logic                    irq_o
);

   // Addresses outside the first 1024 bytes or misaligned map to a dead index
   function automatic logic [7:0] reg_idx(input logic [31:0] addr);
      logic [7:0] idx;
      idx = EIPU_IDX_NONE;
      if (addr[31:10] == 22'h0 && addr[1:0] == 2'b00) begin
         idx = addr[9:2];
      end
      return idx;
   endfunction : reg_idx

   logic [PC_PINS-1:0] pinchg_mask_bits;
   logic               pinchg_flag;
   logic               pinchg_irq_enable;
   logic               ext_enable;
   logic               ext_irq_flag;
   eipu_sense_t        sense_sel;
   logic [1:0]         irq_status;
   logic [1:0]         irq_mask;

   logic               wr_pend;
   logic [7:0]         wr_idx;
   logic [7:0]         rd_idx;
   logic [31:0]        next_rdata;
   logic               addr_phase;

   logic               ext_lvl;
   logic               ext_rise;
   logic               ext_fall;
   logic               ext_chg;
   logic [PC_PINS-1:0] pc_lvl;
   logic [PC_PINS-1:0] pc_chg;
   logic               ext_evt;
   logic               pc_evt;
   logic               ext_low_active;
   logic               next_ext_req;
   logic               next_pc_req;
   logic               ext_flag_clr;
   logic               pc_flag_clr;
   logic [1:0]         stat_clr;

   // Pins are read whatever their direction, so software can drive them  (see [R07])
   eipu_sync_edge #(
      .WIDTH    (1)
   ) u_ext_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i   (rstn_i),
      .pin_i    (ext_irq_pin_i),
      .level_o  (ext_lvl),
      .rise_o   (ext_rise),
      .fall_o   (ext_fall),
      .change_o (ext_chg)
   ); // see [R03] see [R18] see [R04]

   eipu_sync_edge #(
      .WIDTH    (PC_PINS)
   ) u_pc_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i   (rstn_i),
      .pin_i    (pinchg_pin_i),
      .level_o  (pc_lvl),
      .rise_o   (),
      .fall_o   (),
      .change_o (pc_chg)
   ); // see [R18]

   // Trigger selection for the dedicated pin
   always_comb begin
      ext_evt = 1'b0;
      case (sense_sel)
         EIPU_SENSE_ANY:  ext_evt = ext_chg;  // see [R02]
         EIPU_SENSE_FALL: ext_evt = ext_fall; // see [R02]
         EIPU_SENSE_RISE: ext_evt = ext_rise; // see [R02]
         default:         ext_evt = 1'b0;
      endcase
   end

   // Level needs no previous sample, unlike the edge modes  (see [R17])
   assign ext_low_active = (sense_sel == EIPU_SENSE_LOW) && !ext_lvl;
   assign pc_evt         = |(pc_chg & pinchg_mask_bits); // see [R13] see [R16]

   // AHB-Lite address phase
   assign addr_phase = hsel_i && htrans_i[1] && hready_i;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_idx(haddr_i) == EIPU_IDX_PC_MASK) begin
         next_rdata[PC_PINS-1:0] = pinchg_mask_bits;
      end else if (reg_idx(haddr_i) == EIPU_IDX_PC_FLAG) begin
         next_rdata[EIPU_FLAG_BIT] = pinchg_flag;
      end else if (reg_idx(haddr_i) == EIPU_IDX_PC_CTRL) begin
         next_rdata[EIPU_ENABLE_BIT] = pinchg_irq_enable;
      end else if (reg_idx(haddr_i) == EIPU_IDX_EXT_MASK) begin
         next_rdata[EIPU_ENABLE_BIT] = ext_enable;
      end else if (reg_idx(haddr_i) == EIPU_IDX_EXT_FLAG) begin
         next_rdata[EIPU_FLAG_BIT] = ext_irq_flag;
      end else if (reg_idx(haddr_i) == EIPU_IDX_EXT_SENSE) begin
         next_rdata[EIPU_SENSE_MSB:EIPU_SENSE_LSB] = sense_sel;
      end else if (reg_idx(haddr_i) == EIPU_IDX_IRQ_STATUS) begin
         next_rdata[EIPU_STAT_W-1:0] = irq_status;
      end else if (reg_idx(haddr_i) == EIPU_IDX_IRQ_MASK) begin
         next_rdata[EIPU_STAT_W-1:0] = irq_mask;
      end
   end // see [R06]

   // Zero wait states; the response never errors
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         hrdata_o    <= 32'h0000_0000;
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
         wr_pend     <= 1'b0;
         wr_idx      <= EIPU_IDX_NONE;
         rd_idx      <= EIPU_IDX_NONE;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         wr_pend     <= addr_phase && hwrite_i;
         wr_idx      <= addr_phase ? reg_idx(haddr_i) : EIPU_IDX_NONE;
         rd_idx      <= (addr_phase && !hwrite_i) ? reg_idx(haddr_i) : EIPU_IDX_NONE;
         if (addr_phase && !hwrite_i) begin
            hrdata_o <= next_rdata;
         end
      end
   end

   // Control registers; only the documented bits are stored
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pinchg_mask_bits  <= EIPU_PC_MASK_RST;
         pinchg_irq_enable <= EIPU_BIT_RST;
         ext_enable        <= EIPU_BIT_RST;
         sense_sel         <= eipu_sense_t'(EIPU_SENSE_RST);
         irq_mask          <= EIPU_STAT_RST;
      end else if (wr_pend) begin
         if (wr_idx == EIPU_IDX_PC_MASK) begin
            pinchg_mask_bits <= hwdata_i[PC_PINS-1:0]; // see [R13]
         end else if (wr_idx == EIPU_IDX_PC_CTRL) begin
            pinchg_irq_enable <= hwdata_i[EIPU_ENABLE_BIT];
         end else if (wr_idx == EIPU_IDX_EXT_MASK) begin
            ext_enable <= hwdata_i[EIPU_ENABLE_BIT];
         end else if (wr_idx == EIPU_IDX_EXT_SENSE) begin
            sense_sel <= eipu_sense_t'(hwdata_i[EIPU_SENSE_MSB:EIPU_SENSE_LSB]);
         end else if (wr_idx == EIPU_IDX_IRQ_MASK) begin
            irq_mask <= hwdata_i[EIPU_STAT_W-1:0];
         end
      end
   end // see [R06]

   assign ext_flag_clr = ext_ack_i || (wr_pend && wr_idx == EIPU_IDX_EXT_FLAG && hwdata_i[EIPU_FLAG_BIT]);
   assign pc_flag_clr  = pinchg_ack_i || (wr_pend && wr_idx == EIPU_IDX_PC_FLAG && hwdata_i[EIPU_FLAG_BIT]);
   assign stat_clr     = (wr_pend && wr_idx == EIPU_IDX_IRQ_STATUS) ? hwdata_i[EIPU_STAT_W-1:0] : 2'b00;

   // Flags: a new event in the clearing cycle wins over the clear
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ext_irq_flag <= EIPU_BIT_RST;
      end else if (sense_sel == EIPU_SENSE_LOW) begin
         ext_irq_flag <= 1'b0; // see [R10]
      end else begin
         ext_irq_flag <= ext_evt || (ext_irq_flag && !ext_flag_clr); // see [R08] see [R09]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pinchg_flag <= EIPU_BIT_RST;
      end else begin
         pinchg_flag <= pc_evt || (pinchg_flag && !pc_flag_clr); // see [R12] see [R09]
      end
   end

   // Sticky event status for the summary interrupt line
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         irq_status <= EIPU_STAT_RST;
      end else begin
         irq_status[EIPU_STAT_EXT_BIT] <= (ext_evt || ext_low_active)
                                          || (irq_status[EIPU_STAT_EXT_BIT] && !stat_clr[EIPU_STAT_EXT_BIT]);
         irq_status[EIPU_STAT_PC_BIT]  <= pc_evt
                                          || (irq_status[EIPU_STAT_PC_BIT] && !stat_clr[EIPU_STAT_PC_BIT]);
      end
   end

   // Low level drives the request directly; edges go through the flag
   assign next_ext_req = global_irq_en_i && ext_enable
                         && ((sense_sel == EIPU_SENSE_LOW) ? !ext_lvl : ext_irq_flag); // see [R01] see [R10]
   assign next_pc_req  = global_irq_en_i && pinchg_irq_enable && pinchg_flag; // see [R11]

   // Request outputs and vector; the lower vector has priority
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ext_req_o        <= 1'b0;
         pinchg_request_o <= 1'b0;
         vector_o         <= EIPU_VEC_NONE;
         irq_o            <= 1'b0;
      end else begin
         ext_req_o        <= next_ext_req;
         pinchg_request_o <= next_pc_req;
         irq_o            <= |(irq_status & irq_mask);
         if (next_ext_req) begin
            vector_o <= EIPU_VEC_EXT; // see [R14] see [R15]
         end else if (next_pc_req) begin
            vector_o <= EIPU_VEC_PINCHG; // see [R14] see [R15]
         end else begin
            vector_o <= EIPU_VEC_NONE;
         end
      end
   end

   AST_EXT_REQ_GATED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R01]
      ext_req_o |-> $past(global_irq_en_i) && $past(ext_enable))
      else $error("external request without both enables");

   AST_LEVEL_FLAG_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R10]
      $past(sense_sel == EIPU_SENSE_LOW) |-> !ext_irq_flag)
      else $error("external flag set in low level mode");

   AST_LEVEL_REQ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R10]
      (sense_sel == EIPU_SENSE_LOW && global_irq_en_i && ext_enable && !ext_lvl) |=> ext_req_o)
      else $error("low level did not raise request");

   AST_LEVEL_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R10]
      (sense_sel == EIPU_SENSE_LOW && ext_lvl) |=> !ext_req_o)
      else $error("low level request stayed after pin went high");

   AST_FALL_SETS_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R08]
      (sense_sel == EIPU_SENSE_FALL && ext_fall) |=> ext_irq_flag)
      else $error("falling edge missed");

   AST_RISE_SETS_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R08]
      (sense_sel == EIPU_SENSE_RISE && ext_rise) |=> ext_irq_flag)
      else $error("rising edge missed");

   AST_ANY_SETS_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R02]
      (sense_sel == EIPU_SENSE_ANY && ext_chg) |=> ext_irq_flag)
      else $error("pin change missed in any change mode");

   AST_RISE_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R02]
      (sense_sel == EIPU_SENSE_RISE && !ext_rise && !ext_irq_flag) |=> !ext_irq_flag)
      else $error("flag set without rising edge");

   AST_FALL_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R02]
      (sense_sel == EIPU_SENSE_FALL && !ext_fall && !ext_irq_flag) |=> !ext_irq_flag)
      else $error("flag set without falling edge");

   AST_SYNC_TWO_STAGE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R03]
      $past(rstn_i, 2) |-> ext_lvl == $past(ext_irq_pin_i, 2))
      else $error("pin level not delayed by two stages");

   AST_PIN_TO_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R12]
      (|((pc_lvl ^ $past(pc_lvl)) & pinchg_mask_bits)) |=> pinchg_flag)
      else $error("masked pin change missed");

   AST_PC_MASKED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R13]
      (!(|(pc_chg & pinchg_mask_bits)) && !pinchg_flag) |=> !pinchg_flag)
      else $error("unmasked pin set the flag");

   AST_W1C_EXT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R09]
      (wr_pend && wr_idx == EIPU_IDX_EXT_FLAG && hwdata_i[0] && !ext_evt) |=> !ext_irq_flag)
      else $error("write one did not clear external flag");

   AST_W1C_PC: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R09]
      (wr_pend && wr_idx == EIPU_IDX_PC_FLAG && hwdata_i[0] && !pc_evt) |=> !pinchg_flag)
      else $error("write one did not clear pin change flag");

   AST_ACK_EXT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R09]
      (ext_ack_i && !ext_evt) |=> !ext_irq_flag)
      else $error("dispatch did not clear external flag");

   AST_ACK_PC: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R09]
      (pinchg_ack_i && !pc_evt) |=> !pinchg_flag)
      else $error("dispatch did not clear pin change flag");

   AST_PC_REQ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R11]
      (pinchg_flag && global_irq_en_i && pinchg_irq_enable) |=> pinchg_request_o)
      else $error("pin change request not raised");

   AST_PC_GATED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R11]
      pinchg_request_o |-> $past(global_irq_en_i) && $past(pinchg_irq_enable))
      else $error("pin change request without both enables");

   AST_VECTORS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R15]
      (ext_req_o |-> vector_o == 16'h0001) and ((pinchg_request_o && !ext_req_o) |-> vector_o == 16'h0002))
      else $error("wrong dispatch vector");

   AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R06]
      (rd_idx == EIPU_IDX_EXT_FLAG || rd_idx == EIPU_IDX_PC_FLAG) |-> hrdata_o[31:1] == 31'h0)
      else $error("reserved flag bits read nonzero");

   AST_RESERVED_CTRL: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R06]
      (rd_idx == EIPU_IDX_PC_CTRL || rd_idx == EIPU_IDX_EXT_MASK) |-> hrdata_o[31:1] == 31'h0)
      else $error("reserved enable bits read nonzero");

   AST_RESERVED_SENSE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R06]
      (rd_idx == EIPU_IDX_EXT_SENSE) |-> hrdata_o[31:2] == 30'h0)
      else $error("reserved sense bits read nonzero");

   AST_RESERVED_MASK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [R06]
      (rd_idx == EIPU_IDX_PC_MASK) |-> hrdata_o[31:PC_PINS] == '0)
      else $error("reserved mask bits read nonzero");

endmodule : eipu_top

// ---- eipu_pin_model.sv ----
// Board-side model that drives the interrupt pins
`timescale 1ns/10ps
module eipu_pin_model
#(
   parameter int PINS = 4
) (
   input  wire logic      sys_clk_i,
   output logic           ext_pin_o,
   output logic [PINS-1:0] pc_pin_o
);
   // Pins idle high as if pulled up; every change comes right after a clock edge
   initial begin
      ext_pin_o = 1'b1;
      pc_pin_o  = '1;
   end

   task automatic set_ext(input logic lvl);
      @(posedge sys_clk_i);
      ext_pin_o <= lvl;  // Level holds until the next call
   endtask : set_ext

   task automatic set_pc(input logic [PINS-1:0] v);
      @(posedge sys_clk_i);
      pc_pin_o <= v;
   endtask : set_pc

   task automatic pulse_ext(input logic lvl, input int cycles);
      set_ext(lvl);
      repeat (cycles) @(posedge sys_clk_i);  // Pulse lasts the given number of clocks, so a cycles of 1 is only one clock
      ext_pin_o <= ~lvl;
   endtask : pulse_ext
endmodule : eipu_pin_model

// ---- testbench.sv ----
// Self-checking testbench for the external pin interrupt unit
`timescale 1ns/10ps
module testbench;
   import eipu_pkg::*;
   logic        sys_clk_i, rstn_i, hsel, hwrite, gen, eack, pack;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, ext_pin, ext_req, pc_req, irq;
   logic [3:0]  pc_pin;
   logic [15:0] vector;
   int          fail_count = 0;
   int          tests_run = 0;

   eipu_top uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .ext_irq_pin_i(ext_pin), .pinchg_pin_i(pc_pin),
      .global_irq_en_i(gen), .ext_ack_i(eack), .pinchg_ack_i(pack), .ext_req_o(ext_req),
      .pinchg_request_o(pc_req), .vector_o(vector), .irq_o(irq));
   eipu_pin_model pins (.sys_clk_i(sys_clk_i), .ext_pin_o(ext_pin), .pc_pin_o(pc_pin));

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [31:0] ad(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction : ad

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : cyc

   // Holds each phase until hready is sampled high; a hang is left to the watchdog
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk_i);
      hsel <= 1'b1; haddr <= ad(idx); htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
      do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wr ? wd : 32'h0000_0000;
      do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, d, rd);
   endtask : wr

   task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0000_0000, rd);
      check(what, rd, exp);
   endtask : rchk

   task automatic t_reset_values;
      for (int i = 16; i < 24; i++) rchk("reset value", 8'(i), 32'h0000_0000);
      rchk("unmapped", 8'h20, 32'h0000_0000);
   endtask : t_reset_values

   task automatic t_reserved;
      logic [7:0]  idx [4] = '{EIPU_IDX_PC_MASK, EIPU_IDX_PC_CTRL, EIPU_IDX_EXT_MASK, EIPU_IDX_EXT_SENSE};
      logic [31:0] exv [4] = '{32'h0000_000F, 32'h0000_0001, 32'h0000_0001, 32'h0000_0003};
      for (int i = 0; i < 4; i++) begin
         wr(idx[i], 32'hFFFF_FFFF);
         rchk("reserved bits", idx[i], exv[i]);
         wr(idx[i], 32'h0000_0000);
      end
   endtask : t_reserved

   task automatic t_edge(input logic [1:0] sns, input logic from_l, input logic to_l, input logic exp);
      pins.set_ext(from_l);
      cyc(5);
      wr(EIPU_IDX_EXT_SENSE, {30'h0, sns});
      wr(EIPU_IDX_EXT_FLAG, 32'h0000_0001);
      pins.set_ext(to_l);
      cyc(6);
      check("ext_req", {31'h0, ext_req}, {31'h0, exp});
      check("vector", {16'h0, vector}, exp ? {16'h0, EIPU_VEC_EXT} : 32'h0000_0000);
      rchk("ext_flag", EIPU_IDX_EXT_FLAG, {31'h0, exp});
      wr(EIPU_IDX_EXT_FLAG, 32'h0000_0001);
      rchk("ext_flag w1c", EIPU_IDX_EXT_FLAG, 32'h0000_0000);
   endtask : t_edge

   task automatic t_low_level;
      wr(EIPU_IDX_EXT_SENSE, 32'h0000_0000);
      pins.set_ext(1'b0);
      cyc(6);
      check("low req", {31'h0, ext_req}, 32'h0000_0001);
      rchk("low flag", EIPU_IDX_EXT_FLAG, 32'h0000_0000);
      pins.set_ext(1'b1);
      cyc(6);
      check("low release", {31'h0, ext_req}, 32'h0000_0000);
   endtask : t_low_level

   task automatic t_enable_ack;
      @(posedge sys_clk_i) gen <= 1'b0;
      wr(EIPU_IDX_EXT_SENSE, 32'h0000_0002);
      wr(EIPU_IDX_EXT_FLAG, 32'h0000_0001);
      pins.pulse_ext(1'b0, 2);
      cyc(6);
      rchk("pulse flag", EIPU_IDX_EXT_FLAG, 32'h0000_0001);
      check("gated req", {31'h0, ext_req}, 32'h0000_0000);
      @(posedge sys_clk_i) gen <= 1'b1;
      cyc(3);
      check("enabled req", {31'h0, ext_req}, 32'h0000_0001);
      check("ext vector", {16'h0, vector}, {16'h0, EIPU_VEC_EXT});
      @(posedge sys_clk_i) eack <= 1'b1;
      @(posedge sys_clk_i) eack <= 1'b0;
      cyc(3);
      check("ack req", {31'h0, ext_req}, 32'h0000_0000);
      rchk("ack flag", EIPU_IDX_EXT_FLAG, 32'h0000_0000);
   endtask : t_enable_ack

   task automatic t_pinchg;
      wr(EIPU_IDX_PC_MASK, 32'h0000_0004);
      wr(EIPU_IDX_PC_CTRL, 32'h0000_0001);
      pins.set_pc(4'hE);
      cyc(6);
      rchk("masked pin", EIPU_IDX_PC_FLAG, 32'h0000_0000);
      pins.set_pc(4'hA);
      cyc(6);
      rchk("pc flag", EIPU_IDX_PC_FLAG, 32'h0000_0001);
      check("pc req", {31'h0, pc_req}, 32'h0000_0001);
      check("pc vector", {16'h0, vector}, {16'h0, EIPU_VEC_PINCHG});
      wr(EIPU_IDX_PC_CTRL, 32'h0000_0000);
      cyc(3);
      check("pc disabled", {31'h0, pc_req}, 32'h0000_0000);
      @(posedge sys_clk_i) pack <= 1'b1;
      @(posedge sys_clk_i) pack <= 1'b0;
      rchk("pc ack", EIPU_IDX_PC_FLAG, 32'h0000_0000);
   endtask : t_pinchg

   task automatic t_irq;
      wr(EIPU_IDX_IRQ_STATUS, 32'h0000_0003);
      rchk("status clr", EIPU_IDX_IRQ_STATUS, 32'h0000_0000);
      pins.set_ext(1'b0);
      cyc(6);
      rchk("status set", EIPU_IDX_IRQ_STATUS, 32'h0000_0001);
      check("irq masked", {31'h0, irq}, 32'h0000_0000);
      wr(EIPU_IDX_IRQ_MASK, 32'h0000_0001);
      cyc(2);
      check("irq on", {31'h0, irq}, 32'h0000_0001);
      wr(EIPU_IDX_IRQ_STATUS, 32'h0000_0001);
      cyc(2);
      check("irq cleared", {31'h0, irq}, 32'h0000_0000);
   endtask : t_irq

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      rstn_i = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = 32'h0000_0000; gen = 1'b0; eack = 1'b0; pack = 1'b0;
      cyc(8);
      rstn_i <= 1'b1;
      cyc(2);
      t_reset_values();
      t_reserved();
      @(posedge sys_clk_i) gen <= 1'b1;
      wr(EIPU_IDX_EXT_MASK, 32'h0000_0001);
      t_edge(2'b01, 1'b0, 1'b1, 1'b1);
      t_edge(2'b01, 1'b1, 1'b0, 1'b1);
      t_edge(2'b10, 1'b1, 1'b0, 1'b1);
      t_edge(2'b10, 1'b0, 1'b1, 1'b0);
      t_edge(2'b11, 1'b0, 1'b1, 1'b1);
      t_edge(2'b11, 1'b1, 1'b0, 1'b0);
      t_low_level();
      t_enable_ack();
      t_pinchg();
      t_irq();
      report_and_stop();
   end

   // Whole run needs well under 2000 cycles; this cuts a hung handshake short
   initial begin
      #(50 * 20000);
      fail_count++;
      report_and_stop();
   end
endmodule : testbench
